// ### pkg/awm_params.svh
// constants for the converter window, input mux and offset trim block
`ifndef AWM_PARAMS_SVH
`define AWM_PARAMS_SVH

`define AWM_ADDR_OFFSET_LOW    8'h85
`define AWM_ADDR_OFFSET_HIGH   8'h86
`define AWM_ADDR_INPUT_SELECT  8'hbb
`define AWM_ADDR_UPPER_LOW     8'hc3
`define AWM_ADDR_UPPER_HIGH    8'hc4
`define AWM_ADDR_LOWER_LOW     8'hc5
`define AWM_ADDR_LOWER_HIGH    8'hc6
`define AWM_ADDR_CONV_CONTROL  8'he8

`define AWM_RST_UPPER_BYTE     8'hff
`define AWM_RST_LOWER_BYTE     8'h00
`define AWM_RST_INPUT_SELECT   5'h1f

`define AWM_SEL_WIDTH          5
`define AWM_SEL_LAST_PIN       5'h14
`define AWM_SEL_TEMP_SENSOR    5'h1e
`define AWM_SEL_SUPPLY         5'h1f
`define AWM_NUM_PINS           21

`define AWM_CTRL_WINDOW_BIT    3
`define AWM_OFFSET_LOW_LSB     6
`define AWM_TRIM_SETTLE_CYCLES 2'h3

`endif

// ### pkg/awm_pkg.sv
// types for the converter window, input mux and offset trim block
package awm_pkg;

	typedef enum logic {
		AWM_MODE_OUTSIDE,
		AWM_MODE_INSIDE
	} awm_mode_t;

	typedef enum logic [1:0] {
		AWM_TRIM_SETTLE,
		AWM_TRIM_LOAD,
		AWM_TRIM_DONE
	} awm_trim_state_t;

endpackage

// ### pkg/awm_win_if.sv
// signals between the register file and the window comparator
`timescale 1ns/1ns
interface awm_win_if;
	logic [15:0]        result;
	logic [15:0]        upper_limit;
	logic [15:0]        lower_limit;
	logic               match;
	awm_pkg::awm_mode_t mode;

	modport regs (output result, output upper_limit, output lower_limit, input match, input mode);
	modport cmp  (input result, input upper_limit, input lower_limit, output match, output mode);
endinterface

// ### verilog/awm_window_cmp.sv
// window comparator on the justified result word
`timescale 1ns/1ns
`include "awm_params.svh"
module awm_window_cmp (
	awm_win_if.cmp win
);
	logic above_upper;
	logic below_lower;

	always_comb begin
		// plain unsigned compares; justification does not matter as both sides share it
		above_upper = win.result > win.upper_limit;
		below_lower = win.result < win.lower_limit;
		// mode comes only from the limit values
		if (win.lower_limit > win.upper_limit) begin
			win.mode  = awm_pkg::AWM_MODE_INSIDE;
			win.match = above_upper && below_lower;
		end else begin
			win.mode  = awm_pkg::AWM_MODE_OUTSIDE;
			// range runs from the less-than limit up to the greater-than limit
			win.match = below_lower || above_upper;
		end
	end
endmodule // awm_window_cmp

// ### verilog/awm_top.sv
// converter window detector, positive input select and temperature offset registers
// What this block does
// - lower limit low byte at 0xc5, read/write, resets to zero.
// - inside mode flags result above upper limit and below lower limit.
// - outside mode flags result below range low end or above high end.
// - results compare as unsigned sixteen-bit words.
// - left-justified words compare directly against limits as written.
// - five-bit select; 11110 temperature sensor, 11111 supply.
// - offset high byte at 0x86 holds bits 9:2, read/write, trimmed reset.
// - stored offset is the left-justified sensor reading at zero degrees.
// - each unit's production offset loads into the registers after reset.
// - offset low at 0x85; bits 7:6 hold offset 1:0, rest read zero.
// - window flag is control bit 3, sticky until software clears it.
// - upper limit bytes 0xc4/0xc3 reset ones; lower high 0xc6 resets zero.
// - inside or outside chosen only by limit values, no mode bit.
`timescale 1ns/1ns
`include "awm_params.svh"
module awm_top (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_we,
	input  wire logic        sfr_re,
	output logic      [7:0]  sfr_rdata,
	input  wire logic        conv_done,
	input  wire logic [15:0] conv_result,
	input  wire logic [9:0]  trim_offset,
	output logic             window_match_flag,
	output logic             window_inside_mode,
	output logic      [4:0]  converter_input_mux,
	output logic      [20:0] port_pin_select,
	output logic             temp_sensor_select,
	output logic             supply_select,
	output logic             trim_loaded
);
	awm_win_if win ();

	logic [7:0]  upper_high_q, upper_high_d;
	logic [7:0]  upper_low_q,  upper_low_d;
	logic [7:0]  lower_high_q, lower_high_d;
	logic [7:0]  lower_low_q,  lower_low_d;
	logic [4:0]  select_q,     select_d;
	logic [9:0]  offset_q,     offset_d;
	logic        flag_q,       flag_d;
	logic        inside_q,     inside_d;
	logic [7:0]  rdata_q,      rdata_d;
	logic [20:0] pins_q,       pins_d;
	logic        temp_q,       temp_d;
	logic        supply_q,     supply_d;

	logic [9:0]  trim_meta_q;
	logic [9:0]  trim_sync_q;
	logic [1:0]  settle_q,     settle_d;
	awm_pkg::awm_trim_state_t trim_state_q, trim_state_d;

	logic        wr_ctrl;

	assign win.result      = conv_result;
	assign win.upper_limit = {upper_high_q, upper_low_q};
	assign win.lower_limit = {lower_high_q, lower_low_q};

	awm_window_cmp u_cmp (
		.win (win.cmp)
	);

	// trim value is static but comes from outside this clock, so synchronise it
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			trim_meta_q <= 10'h000;
			trim_sync_q <= 10'h000;
		end else begin
			trim_meta_q <= trim_offset;
			trim_sync_q <= trim_meta_q;
		end
	end

	// offset load sequencer; async reset can only give a constant, so load after release
	always_comb begin
		trim_state_d = trim_state_q;
		settle_d     = settle_q;
		case (trim_state_q)
			awm_pkg::AWM_TRIM_SETTLE: begin
				settle_d = settle_q + 2'h1;
				if (settle_q == `AWM_TRIM_SETTLE_CYCLES) begin
					trim_state_d = awm_pkg::AWM_TRIM_LOAD;
				end
			end
			awm_pkg::AWM_TRIM_LOAD: begin
				trim_state_d = awm_pkg::AWM_TRIM_DONE;
			end
			awm_pkg::AWM_TRIM_DONE: begin
				trim_state_d = awm_pkg::AWM_TRIM_DONE;
			end
			default: begin
				trim_state_d = awm_pkg::AWM_TRIM_SETTLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			trim_state_q <= awm_pkg::AWM_TRIM_SETTLE;
			settle_q     <= 2'h0;
		end else begin
			trim_state_q <= trim_state_d;
			settle_q     <= settle_d;
		end
	end

	// register writes
	always_comb begin
		upper_high_d = upper_high_q;
		upper_low_d  = upper_low_q;
		lower_high_d = lower_high_q;
		lower_low_d  = lower_low_q;
		select_d     = select_q;
		offset_d     = offset_q;
		if (trim_state_q == awm_pkg::AWM_TRIM_LOAD) begin
			offset_d = trim_sync_q;
		end
		if (sfr_we) begin
			case (sfr_addr)
				`AWM_ADDR_UPPER_HIGH:   upper_high_d = sfr_wdata;
				`AWM_ADDR_UPPER_LOW:    upper_low_d  = sfr_wdata;
				`AWM_ADDR_LOWER_HIGH:   lower_high_d = sfr_wdata;
				`AWM_ADDR_LOWER_LOW:    lower_low_d  = sfr_wdata;
				`AWM_ADDR_INPUT_SELECT: select_d     = sfr_wdata[4:0];
				`AWM_ADDR_OFFSET_HIGH:  offset_d[9:2] = sfr_wdata;
				`AWM_ADDR_OFFSET_LOW:   offset_d[1:0] = sfr_wdata[7:6];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			upper_high_q <= `AWM_RST_UPPER_BYTE;
			upper_low_q  <= `AWM_RST_UPPER_BYTE;
			lower_high_q <= `AWM_RST_LOWER_BYTE;
			lower_low_q  <= `AWM_RST_LOWER_BYTE;
			select_q     <= `AWM_RST_INPUT_SELECT;
			offset_q     <= 10'h000;
		end else begin
			upper_high_q <= upper_high_d;
			upper_low_q  <= upper_low_d;
			lower_high_q <= lower_high_d;
			lower_low_q  <= lower_low_d;
			select_q     <= select_d;
			offset_q     <= offset_d;
		end
	end

	// window flag: a match in the clearing cycle wins so no event is lost
	assign wr_ctrl = sfr_we && (sfr_addr == `AWM_ADDR_CONV_CONTROL);

	always_comb begin
		flag_d   = flag_q;
		inside_d = (win.mode == awm_pkg::AWM_MODE_INSIDE);
		if (wr_ctrl && !sfr_wdata[`AWM_CTRL_WINDOW_BIT]) begin
			flag_d = 1'b0;
		end
		if (conv_done && win.match) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flag_q   <= 1'b0;
			inside_q <= 1'b0;
		end else begin
			flag_q   <= flag_d;
			inside_q <= inside_d;
		end
	end

	// input mux decode, registered so the analog switches see clean levels
	always_comb begin
		pins_d   = 21'h000000;
		temp_d   = 1'b0;
		supply_d = 1'b0;
		if (select_q <= `AWM_SEL_LAST_PIN) begin
			pins_d[select_q] = 1'b1;
		end else if (select_q == `AWM_SEL_TEMP_SENSOR) begin
			temp_d = 1'b1;
		end else if (select_q == `AWM_SEL_SUPPLY) begin
			supply_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pins_q   <= 21'h000000;
			temp_q   <= 1'b0;
			supply_q <= 1'b0;
		end else begin
			pins_q   <= pins_d;
			temp_q   <= temp_d;
			supply_q <= supply_d;
		end
	end

	// read data, one cycle after the read strobe; unmapped addresses give zero
	always_comb begin
		rdata_d = rdata_q;
		if (sfr_re) begin
			case (sfr_addr)
				`AWM_ADDR_UPPER_HIGH:   rdata_d = upper_high_q;
				`AWM_ADDR_UPPER_LOW:    rdata_d = upper_low_q;
				`AWM_ADDR_LOWER_HIGH:   rdata_d = lower_high_q;
				`AWM_ADDR_LOWER_LOW:    rdata_d = lower_low_q;
				`AWM_ADDR_INPUT_SELECT: rdata_d = {3'h0, select_q};
				`AWM_ADDR_OFFSET_HIGH:  rdata_d = offset_q[9:2];
				`AWM_ADDR_OFFSET_LOW:   rdata_d = {offset_q[1:0], 6'h00};
				`AWM_ADDR_CONV_CONTROL: rdata_d = {4'h0, flag_q, 3'h0};
				default:                rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata           = rdata_q;
	assign window_match_flag   = flag_q;
	assign window_inside_mode  = inside_q;
	assign converter_input_mux = select_q;
	assign port_pin_select     = pins_q;
	assign temp_sensor_select  = temp_q;
	assign supply_select       = supply_q;
	assign trim_loaded         = (trim_state_q == awm_pkg::AWM_TRIM_DONE);
endmodule // awm_top

// ### verif/awm_top_monitor.sv
// concurrent checks on the window, select and offset block ports
`timescale 1ns/1ns
module awm_top_monitor (
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic [7:0]  sfr_addr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic        sfr_we,
	input wire logic        sfr_re,
	input wire logic [7:0]  sfr_rdata,
	input wire logic        conv_done,
	input wire logic [15:0] conv_result,
	input wire logic        window_match_flag,
	input wire logic        window_inside_mode,
	input wire logic [4:0]  converter_input_mux,
	input wire logic [20:0] port_pin_select,
	input wire logic        temp_sensor_select,
	input wire logic        supply_select
);
	logic [15:0] up_q, lo_q;
	logic [4:0]  sel_w;
	logic        ins, hit, clr;
	assign sel_w = sfr_wdata[4:0];
	assign ins   = lo_q > up_q;
	assign hit   = ins ? (conv_result > up_q && conv_result < lo_q) : (conv_result < lo_q || conv_result > up_q);
	assign clr   = sfr_we && sfr_addr == 8'he8 && !sfr_wdata[3];
	// shadow limits from bus writes, so no design internals are needed
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			up_q <= 16'hffff;
			lo_q <= 16'h0000;
		end else if (sfr_we) begin
			case (sfr_addr)
				8'hc3: up_q[7:0] <= sfr_wdata;
				8'hc4: up_q[15:8] <= sfr_wdata;
				8'hc5: lo_q[7:0] <= sfr_wdata;
				8'hc6: lo_q[15:8] <= sfr_wdata;
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_hit;
		conv_done && hit;
	endsequence
	sequence s_clear;
		window_match_flag && clr && !conv_done;
	endsequence
	AST_FLAG_SET: assert property (s_hit |=> window_match_flag)
		else $error("window flag missed a match");
	AST_FLAG_CAUSE: assert property (!window_match_flag && !(conv_done && hit) |=> !window_match_flag)
		else $error("window flag rose without a match");
	AST_FLAG_HOLD: assert property (window_match_flag && !clr |=> window_match_flag)
		else $error("window flag dropped without a clear");
	AST_FLAG_CLEAR: assert property (s_clear |=> !window_match_flag)
		else $error("window flag not cleared");
	AST_MODE: assert property (window_inside_mode == $past(ins))
		else $error("inside mode wrong for the limits");
	AST_MUX_WRITE: assert property (sfr_we && sfr_addr == 8'hbb |=> converter_input_mux == $past(sel_w))
		else $error("select code not taken");
	AST_PIN_MAP: assert property (converter_input_mux <= 5'h14 |=> port_pin_select == 21'h1 << $past(converter_input_mux))
		else $error("pin select wrong");
	AST_SENSOR: assert property (converter_input_mux == 5'h1e |=> temp_sensor_select && port_pin_select == 21'h0)
		else $error("sensor not selected");
	AST_SUPPLY: assert property (converter_input_mux == 5'h1f |=> supply_select && !temp_sensor_select)
		else $error("supply not selected");
	AST_LOW_READ: assert property (sfr_re && !sfr_we && sfr_addr == 8'hc5 |=> sfr_rdata == lo_q[7:0])
		else $error("lower low byte read wrong");
endmodule // awm_top_monitor

bind awm_top awm_top_monitor i_mon (.sys_clk, .reset_n, .sfr_addr, .sfr_wdata, .sfr_we, .sfr_re, .sfr_rdata,
	.conv_done, .conv_result, .window_match_flag, .window_inside_mode, .converter_input_mux,
	.port_pin_select, .temp_sensor_select, .supply_select);

// ### verif/awm_conv_model.sv
// behavioural converter core: result strobes and production trim
`timescale 1ns/1ns
module awm_conv_model #(
	parameter logic [9:0] TRIM = 10'h2b5
) (
	input  wire logic        sys_clk,
	output logic             conv_done,
	output logic      [15:0] conv_result,
	output logic      [9:0]  trim_offset
);
	assign trim_offset = TRIM;
	initial begin
		conv_done   = 1'b0;
		conv_result = 16'h0000;
	end
	// word is inverted outside the strobe so no stale value is held; conv_done low keeps it from setting the flag
	task automatic convert(input logic [15:0] r);
		@(negedge sys_clk);
		conv_done   = 1'b1;
		conv_result = r;
		@(negedge sys_clk);
		conv_done   = 1'b0;
		conv_result = ~r;
	endtask
endmodule // awm_conv_model

// ### verif/adc_window_mux_tempcal_bench.sv
// self-checking bench for the window, select and offset block
`timescale 1ns/1ns
module adc_window_mux_tempcal_bench;
	logic        sys_clk, reset_n, sfr_we, sfr_re, conv_done, trim_loaded;
	logic        window_match_flag, window_inside_mode, temp_sensor_select, supply_select;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
	logic [15:0] conv_result;
	logic [9:0]  trim_offset;
	logic [4:0]  converter_input_mux;
	logic [20:0] port_pin_select;
	int          failures = 0;
	int          cmp_count = 0;
	localparam logic [9:0]  TRIM = 10'h2b5;
	localparam logic [15:0] RST_TAB [7] = '{16'hc3ff, 16'hc4ff, 16'hc500, 16'hc600, 16'hbb1f, 16'he800, 16'h1000};
	// upper, lower, result, expected flag
	localparam logic [48:0] WIN_TAB [11] = '{
		{16'h0040, 16'h0080, 16'h0040, 1'b0}, {16'h0040, 16'h0080, 16'h0041, 1'b1},
		{16'h0040, 16'h0080, 16'h007f, 1'b1}, {16'h0040, 16'h0080, 16'h0080, 1'b0},
		{16'h0080, 16'h0040, 16'h003f, 1'b1}, {16'h0080, 16'h0040, 16'h0040, 1'b0},
		{16'h0080, 16'h0040, 16'h0080, 1'b0}, {16'h0080, 16'h0040, 16'h0081, 1'b1},
		{16'h1000, 16'h2000, 16'h1040, 1'b1}, {16'h1000, 16'h2000, 16'hffc0, 1'b0},
		{16'h0200, 16'h0100, 16'h03ff, 1'b1}};

	awm_top i_dut (.sys_clk, .reset_n, .sfr_addr, .sfr_wdata, .sfr_we, .sfr_re, .sfr_rdata, .conv_done,
		.conv_result, .trim_offset, .window_match_flag, .window_inside_mode, .converter_input_mux,
		.port_pin_select, .temp_sensor_select, .supply_select, .trim_loaded);
	awm_conv_model #(.TRIM(TRIM)) i_model (.sys_clk, .conv_done, .conv_result, .trim_offset);

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// strobe drops one cycle later, so back-to-back calls never double-drive it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr  = a;
		sfr_wdata = d;
		sfr_we    = 1'b1;
		@(negedge sys_clk);
		sfr_we = 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_re   = 1'b1;
		@(negedge sys_clk);
		sfr_re = 1'b0;
		check(sfr_rdata, exp);
	endtask
	task automatic win(input logic [15:0] up, input logic [15:0] lo, input logic [15:0] res, input logic f);
		wr(8'hc4, up[15:8]);
		wr(8'hc3, up[7:0]);
		wr(8'hc6, lo[15:8]);
		wr(8'hc5, lo[7:0]);
		wr(8'he8, 8'h00);
		check(window_inside_mode, lo > up);
		check(window_match_flag, 1'b0);
		i_model.convert(res);
		check(window_match_flag, f);
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		reset_n   = 1'b0;
		sfr_we    = 1'b0;
		sfr_re    = 1'b0;
		sfr_addr  = 8'h00;
		sfr_wdata = 8'h00;
		repeat (12) @(negedge sys_clk);
		reset_n = 1'b1;
		foreach (RST_TAB[k]) rd_chk(RST_TAB[k][15:8], RST_TAB[k][7:0]);
		for (int i = 0; i < 20 && trim_loaded !== 1'b1; i++) @(negedge sys_clk);
		check(trim_loaded, 1'b1);
		rd_chk(8'h86, TRIM[9:2]);
		rd_chk(8'h85, {TRIM[1:0], 6'h00});
		wr(8'h86, 8'h5a);
		wr(8'h85, 8'hff);
		rd_chk(8'h86, 8'h5a);
		rd_chk(8'h85, 8'hc0);
		for (int c = 0; c < 32; c++) begin
			wr(8'hbb, {3'h7, c[4:0]});
			@(negedge sys_clk);
			check(converter_input_mux, c[4:0]);
			check({port_pin_select, temp_sensor_select, supply_select}, {(c < 21) ? 21'h1 << c : 21'h0, c == 30, c == 31});
		end
		// conversions stay on the supply, so no pin setup or sensor enable is owed
		wr(8'hbb, 8'h1f);
		rd_chk(8'hbb, 8'h1f);
		foreach (WIN_TAB[k]) win(WIN_TAB[k][48:33], WIN_TAB[k][32:17], WIN_TAB[k][16:1], WIN_TAB[k][0]);
		i_model.convert(16'h0200);
		check(window_match_flag, 1'b1);
		wr(8'he8, 8'h08);
		check(window_match_flag, 1'b1);
		rd_chk(8'he8, 8'h08);
		// clear and match in one cycle: the set must win
		fork
			wr(8'he8, 8'h00);
			i_model.convert(16'h03ff);
		join
		check(window_match_flag, 1'b1);
		wr(8'he8, 8'h00);
		check(window_match_flag, 1'b0);
		report_and_stop();
	end
endmodule // adc_window_mux_tempcal_bench
